// ==== hw/csc_irq.sv ====
`timescale 1ns/1ps
module csc_irq import csc_pkg::*; #(
	parameter int N = IRQ_N
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [N-1:0] set,
	input wire logic [N-1:0] clr,
	input wire logic [N-1:0] en,
	output logic [N-1:0] status,
	output logic irq
);
	if (N < 1 || N > DATA_W) begin : g_count_chk
		$error("csc_irq: event count out of range");
	end

	// Sticky status; an event in the clearing cycle survives
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) status <= '0;
		else status <= (status & ~clr) | set;
	end

	// Registered level output
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) irq <= 1'b0;
		else irq <= |(((status & ~clr) | set) & en);
	end
endmodule // csc_irq

// ==== hw/csc_pkg.sv ====
package csc_pkg;

	// Register port widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [15:0] OFS_SLOT_HIGH = 16'hffd7;
	localparam logic [15:0] OFS_SLOT_LOW = 16'hffd8;
	localparam logic [15:0] OFS_DATA_HIGH = 16'hffd9;
	localparam logic [15:0] OFS_DATA_LOW = 16'hffda;
	localparam logic [15:0] OFS_CMD_ADDR = 16'hffdb;
	localparam logic [15:0] OFS_CTRL = 16'hffe0;
	localparam logic [15:0] OFS_IRQ_STAT = 16'hffe1;
	localparam logic [15:0] OFS_IRQ_CLR = 16'hffe2;
	localparam logic [15:0] OFS_IRQ_EN = 16'hffe3;

	// Reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;

	// Field layout of the slot valid registers
	localparam int SVH_FRAME_VALID = 7;
	localparam int SVH_PRI_READY = 6;
	localparam int SVH_SEC_READY = 5;
	localparam logic [7:0] SVH_SLOT_MASK = 8'h1f;
	localparam logic [7:0] SVL_SLOT_MASK = 8'hf8;
	localparam logic [7:0] SVH_RW_MASK = 8'h9f;

	// Command address fields
	localparam int CMD_RW_BIT = 7;
	localparam int AC_ADDR_W = 7;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SEL_LSB = 2;
	localparam int CTRL_BUSY_BIT = 7;

	// Frame layout
	localparam int CNT_W = 8;
	localparam logic [7:0] AC_FRAME_LAST = 8'hff;
	localparam logic [7:0] SHORT_FRAME_LAST = 8'h0f;
	localparam logic [7:0] TAG_BITS = 8'h10;
	localparam int SLOT_BITS = 20;
	localparam int TAG_MSB = 15;
	localparam int TAG_CMD_VALID = 14;
	localparam int TAG_DATA_VALID = 13;
	localparam int TAG_SLOT3 = 12;
	localparam int SLOT_MSB = 19;
	localparam int CMD_FIELD_LSB = 12;
	localparam int DATA_FIELD_LSB = 4;
	localparam int DATA_FIELD_MSB = 19;

	// Interrupt events
	localparam int IRQ_N = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_PRI_READY = 1;
	localparam int IRQ_SEC_READY = 2;

	// Link clock must be slow enough for the system clock to see both phases
	localparam int LINK_PERIOD_NS = 125;
	localparam int MCLK_PERIOD_NS = 8;
	localparam int LINK_CYCLES = LINK_PERIOD_NS / MCLK_PERIOD_NS;
	localparam int LINK_MIN_CYCLES = 6;

	typedef enum logic [1:0] {MODE_GP, MODE_AC97, MODE_AC97_DUAL, MODE_SHORT} csc_mode_t;

	typedef struct packed {
		logic sclk;
		logic sdin_p;
		logic sdin_s;
	} csc_link_t;

	typedef struct packed {
		csc_mode_t mode;
		logic [1:0] sel;
	} csc_ctrl_t;

	typedef struct packed {
		logic [3:0] slot;
		logic [4:0] bitn;
	} csc_pos_t;

endpackage

// ==== hw/csc_sync.sv ====
`timescale 1ns/1ps
module csc_sync import csc_pkg::*; #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	if (W < 1) begin : g_width_chk
		$error("csc_sync: width must be positive");
	end

	// Two stages; the first stage feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // csc_sync

// ==== hw/csc_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module csc_top import csc_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic sclk,
	input wire logic sdin_p,
	input wire logic sdin_s,
	output logic sdout,
	output logic sync,
	output logic irq
);
	typedef enum {TS_IDLE, TS_SEND, TS_WAIT} csc_txn_t;

	if (LINK_CYCLES < LINK_MIN_CYCLES) begin : g_link_chk
		$error("csc_top: link clock too fast to sample");
	end

	// Bit position within an AC97 frame to slot and bit number
	function automatic csc_pos_t ac_pos(input logic [CNT_W-1:0] p);
		csc_pos_t r;
		int q;
		r = '0;
		if (p < TAG_BITS) begin
			r.slot = 4'h0;
			r.bitn = 5'(TAG_MSB - int'(p));
		end else begin
			q = int'(p) - int'(TAG_BITS);
			r.slot = 4'(1 + q / SLOT_BITS);
			r.bitn = 5'(SLOT_MSB - q % SLOT_BITS);
		end
		return r;
	endfunction

	function automatic logic is_ac97(input csc_mode_t m);
		return (m == MODE_AC97) || (m == MODE_AC97_DUAL);
	endfunction

	// Software registers
	logic [7:0] cmd_addr;
	logic [7:0] data_hi;
	logic [7:0] data_lo;
	logic [7:0] slot_lo;
	logic [7:0] slot_hi;
	logic pri_ready;
	logic sec_ready;
	csc_ctrl_t ctrl;
	logic [IRQ_N-1:0] irq_en;
	logic [IRQ_N-1:0] irq_status;

	// Transaction state
	csc_txn_t txn;
	logic pending;
	logic op_read;
	logic [AC_ADDR_W-1:0] rx_addr;
	logic [15:0] rx_data;

	// Link sampling
	csc_link_t link_raw;
	csc_link_t link_q;
	logic sclk_d;
	logic sclk_rise;
	logic sclk_fall;
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] rx_idx;
	logic [CNT_W-1:0] frame_last;
	logic ac_mode;
	logic rx_sel_bit;
	logic frame_end;
	logic frame_start;

	// Decoded strobes and events
	logic wr_cmd;
	logic [IRQ_N-1:0] irq_set;
	logic [IRQ_N-1:0] irq_clr;
	logic done;
	logic next_tx;
	csc_pos_t tx_pos;
	csc_pos_t rx_pos;
	logic [15:0] data_word;

	assign link_raw = '{sclk: sclk, sdin_p: sdin_p, sdin_s: sdin_s};

	csc_sync #(.W($bits(csc_link_t))) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d(link_raw),
		.q(link_q)
	);

	// Edges of the sampled link clock
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) sclk_d <= 1'b0;
		else sclk_d <= link_q.sclk;
	end

	assign sclk_rise = link_q.sclk & ~sclk_d;
	assign sclk_fall = ~link_q.sclk & sclk_d;
	assign ac_mode = is_ac97(ctrl.mode);
	assign frame_last = ac_mode ? AC_FRAME_LAST : SHORT_FRAME_LAST;
	assign frame_start = sclk_rise && (bit_cnt == '0);
	assign frame_end = sclk_fall && (rx_idx == frame_last);
	assign wr_cmd = wr && (addr == OFS_CMD_ADDR);
	assign data_word = {data_hi, data_lo};
	assign tx_pos = ac_pos(bit_cnt);
	assign rx_pos = ac_pos(rx_idx);
	// Selector picks which codec answers reads in AC97 modes
	assign rx_sel_bit = (ac_mode && ctrl.sel != 2'b00) ? link_q.sdin_s : link_q.sdin_p;

	// Bit counter; a mode change takes effect at once, wrapping at the next rise if already past the new frame end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bit_cnt <= '0;
			rx_idx <= '0;
		end else if (sclk_rise) begin
			rx_idx <= bit_cnt;
			bit_cnt <= (bit_cnt >= frame_last) ? '0 : bit_cnt + 1'b1;
		end
	end

	// Outgoing bit for the current position
	always_comb begin
		next_tx = 1'b0;
		if (!ac_mode) begin
			// One 16-bit word, command byte first; bit 0 leaves before txn shows SEND
			if (txn == TS_SEND || (frame_start && txn == TS_IDLE && pending)) begin
				next_tx = (bit_cnt < 8'h08) ? cmd_addr[3'(7 - int'(bit_cnt))]
					: data_lo[3'(15 - int'(bit_cnt))];
			end
		end else begin
			case (tx_pos.slot)
				4'h0: begin
					if (int'(tx_pos.bitn) == TAG_MSB) begin
						next_tx = slot_hi[SVH_FRAME_VALID];
					end else if (int'(tx_pos.bitn) == TAG_CMD_VALID) begin
						next_tx = (txn == TS_SEND);
					end else if (int'(tx_pos.bitn) == TAG_DATA_VALID) begin
						next_tx = (txn == TS_SEND) && !op_read;
					end else if (int'(tx_pos.bitn) >= TAG_SLOT3 - 4) begin
						next_tx = slot_hi[3'(int'(tx_pos.bitn) - (TAG_SLOT3 - 4))];
					end else if (int'(tx_pos.bitn) >= TAG_SLOT3 - 9) begin
						next_tx = slot_lo[3'(tx_pos.bitn)];
					end else begin
						next_tx = (tx_pos.bitn[4:1] == 4'h0) ? ctrl.sel[tx_pos.bitn[0]] : 1'b0;
					end
				end
				4'h1: begin
					if (txn == TS_SEND && int'(tx_pos.bitn) >= CMD_FIELD_LSB) begin
						next_tx = cmd_addr[3'(int'(tx_pos.bitn) - CMD_FIELD_LSB)];
					end
				end
				4'h2: begin
					if (txn == TS_SEND && !op_read && int'(tx_pos.bitn) >= DATA_FIELD_LSB) begin
						next_tx = data_word[4'(int'(tx_pos.bitn) - DATA_FIELD_LSB)];
					end
				end
				default: next_tx = 1'b0;
			endcase
		end
	end

	// Serial output and frame sync, both launched on the link rising edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sdout <= 1'b0;
			sync <= 1'b0;
		end else if (sclk_rise) begin
			sdout <= next_tx;
			sync <= ac_mode ? (bit_cnt < TAG_BITS) : (bit_cnt == '0);
		end
	end

	// Transaction sequencing: send in one frame, read status expected in the next
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txn <= TS_IDLE;
			op_read <= 1'b0;
		end else if (frame_start && txn == TS_IDLE && pending) begin
			txn <= TS_SEND;
			op_read <= cmd_addr[CMD_RW_BIT];
		end else if (frame_end && txn == TS_SEND) begin
			txn <= op_read ? TS_WAIT : TS_IDLE;
		end else if (frame_end && txn == TS_WAIT) begin
			txn <= TS_IDLE;
		end
	end

	assign done = frame_end && (txn == TS_WAIT || (txn == TS_SEND && !op_read));

	// Pending request; a new write in the launch cycle keeps it pending
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) pending <= 1'b0;
		else pending <= wr_cmd | (pending & ~(frame_start && txn == TS_IDLE));
	end

	// Returned address and status data, sampled on the link falling edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_addr <= '0;
			rx_data <= '0;
		end else if (sclk_fall && txn == TS_WAIT) begin
			if (!ac_mode) begin
				rx_data[4'(15 - int'(rx_idx))] <= link_q.sdin_p;
			end else if (rx_pos.slot == 4'h1 && int'(rx_pos.bitn) >= CMD_FIELD_LSB
				&& int'(rx_pos.bitn) < CMD_FIELD_LSB + AC_ADDR_W) begin
				rx_addr[3'(int'(rx_pos.bitn) - CMD_FIELD_LSB)] <= rx_sel_bit;
			end else if (rx_pos.slot == 4'h2 && int'(rx_pos.bitn) >= DATA_FIELD_LSB) begin
				rx_data[4'(int'(rx_pos.bitn) - DATA_FIELD_LSB)] <= rx_sel_bit;
			end
		end
	end

	// Codec ready flags, refreshed from slot 0 bit 15 every AC97 frame
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pri_ready <= 1'b0;
			sec_ready <= 1'b0;
		end else if (sclk_fall && ac_mode && rx_idx == '0) begin
			pri_ready <= link_q.sdin_p;
			sec_ready <= link_q.sdin_s;
		end
	end

	// Command address; in AC97 modes a finishing read beats a software write in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_addr <= REG_RESET;
		end else if (done && op_read && ac_mode) begin
			cmd_addr[AC_ADDR_W-1:0] <= rx_addr;
		end else if (wr_cmd) begin
			cmd_addr <= wdata;
		end
	end

	// Data bytes; outside AC97 modes a finishing read leaves the high byte alone
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_hi <= REG_RESET;
			data_lo <= REG_RESET;
		end else if (done && op_read) begin
			data_lo <= rx_data[7:0];
			if (ac_mode) data_hi <= rx_data[15:8];
		end else if (wr) begin
			if (addr == OFS_DATA_LOW) data_lo <= wdata;
			if (addr == OFS_DATA_HIGH) data_hi <= wdata;
		end
	end

	// Slot valid registers; reserved and read-only bits never store
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			slot_lo <= REG_RESET;
			slot_hi <= REG_RESET;
		end else if (wr) begin
			if (addr == OFS_SLOT_LOW) slot_lo <= wdata & SVL_SLOT_MASK;
			if (addr == OFS_SLOT_HIGH) slot_hi <= wdata & SVH_RW_MASK;
		end
	end

	// Mode, codec selector and interrupt enables
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl <= '{mode: MODE_GP, sel: 2'b00};
			irq_en <= '0;
		end else if (wr) begin
			if (addr == OFS_CTRL) begin
				ctrl.mode <= csc_mode_t'(wdata[CTRL_MODE_LSB +: 2]);
				ctrl.sel <= wdata[CTRL_SEL_LSB +: 2];
			end
			if (addr == OFS_IRQ_EN) irq_en <= wdata[IRQ_N-1:0];
		end
	end

	// Events: completion and ready flags rising
	logic pri_ready_d;
	logic sec_ready_d;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pri_ready_d <= 1'b0;
			sec_ready_d <= 1'b0;
		end else begin
			pri_ready_d <= pri_ready;
			sec_ready_d <= sec_ready;
		end
	end

	always_comb begin
		irq_set = '0;
		irq_set[IRQ_DONE] = done;
		irq_set[IRQ_PRI_READY] = pri_ready & ~pri_ready_d;
		irq_set[IRQ_SEC_READY] = sec_ready & ~sec_ready_d;
	end

	assign irq_clr = (wr && addr == OFS_IRQ_CLR) ? wdata[IRQ_N-1:0] : '0;

	csc_irq #(.N(IRQ_N)) u_irq (
		.mclk(mclk),
		.rst(rst),
		.set(irq_set),
		.clr(irq_clr),
		.en(irq_en),
		.status(irq_status),
		.irq(irq)
	);

	// Read data stands one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				OFS_SLOT_HIGH: begin
					rdata <= slot_hi;
					rdata[SVH_PRI_READY] <= pri_ready;
					rdata[SVH_SEC_READY] <= sec_ready;
				end
				OFS_SLOT_LOW: rdata <= slot_lo;
				OFS_DATA_HIGH: rdata <= data_hi;
				OFS_DATA_LOW: rdata <= data_lo;
				OFS_CMD_ADDR: rdata <= cmd_addr;
				OFS_CTRL: begin
					rdata <= '0;
					rdata[CTRL_MODE_LSB +: 2] <= ctrl.mode;
					rdata[CTRL_SEL_LSB +: 2] <= ctrl.sel;
					rdata[CTRL_BUSY_BIT] <= pending || txn != TS_IDLE;
				end
				OFS_IRQ_STAT: rdata <= 8'(irq_status);
				OFS_IRQ_EN: rdata <= 8'(irq_en);
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end
endmodule // csc_top

// ==== tb/csc_chk.sv ====
`timescale 1ns/1ps
module csc_chk import csc_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic sclk,
	input wire logic sync,
	input wire logic sdout,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Write immediately followed by a read of the same place
	sequence s_wr_rd(a);
		wr && addr == a ##1 rd && addr == a;
	endsequence
	// Writable bits come back, fixed bits read as the expected mask
	property p_back(a, m, e);
		s_wr_rd(a) |=> (rdata & m) == ($past(wdata, 2) & e);
	endproperty
	AST_RESET_OUT: assert property ($fell(rst) |-> !sdout && !sync && !irq)
		else $error("outputs not idle after reset");
	AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
		else $error("read data without a read");
	AST_UNMAPPED: assert property (rd && (addr < OFS_SLOT_HIGH || addr > OFS_IRQ_EN)
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	AST_RSVD_LOW: assert property (rd && addr == OFS_SLOT_LOW |=> rdata[2:0] == 3'h0)
		else $error("reserved slot bits not zero");
	AST_SLOT_HIGH: assert property (p_back(OFS_SLOT_HIGH, 8'h9f, 8'h9f))
		else $error("slot high readback");
	AST_SLOT_LOW: assert property (p_back(OFS_SLOT_LOW, 8'hff, 8'hf8))
		else $error("slot low readback");
	AST_DATA_HIGH: assert property (p_back(OFS_DATA_HIGH, 8'hff, 8'hff))
		else $error("data high readback");
	AST_DATA_LOW: assert property (p_back(OFS_DATA_LOW, 8'hff, 8'hff))
		else $error("data low readback");
	AST_CMD_ADDR: assert property (p_back(OFS_CMD_ADDR, 8'hff, 8'hff))
		else $error("command address readback");
	AST_SYNC_HOLD: assert property ($rose(sync) |-> sync[*8])
		else $error("frame sync too short");
	// Outputs move shortly after a link rise, so the link clock is still high
	AST_TX_EDGE: assert property ($changed(sdout) || $changed(sync) |-> sclk)
		else $error("serial output moved off the link rise");
endmodule // csc_chk

bind csc_top csc_chk csc_chk_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .sclk(sclk), .sync(sync), .sdout(sdout), .irq(irq));

// ==== tb/csc_codec_model.sv ====
`timescale 1ns/1ps
module csc_codec_model (
	input wire logic sync,
	input wire logic sdout,
	input wire logic [23:0] reply_p,
	input wire logic [23:0] reply_s,
	output logic sclk,
	output logic sdin_p,
	output logic sdin_s,
	output logic [255:0] cmd_frame,
	output logic [15:0] short_word
);
	logic [255:0] tx_p, tx_s, rx;
	int ti, ri;
	// Reply frame: ready first, address in slot 1, data in slot 2
	function automatic logic [255:0] mk(input logic [23:0] r);
		mk = '0;
		mk[255] = r[23];
		mk[238 -: 7] = r[22:16];
		mk[219 -: 16] = r[15:0];
	endfunction
	// The bit clock runs free, as a codec's does
	initial begin
		sclk = 1'b0;
		sdin_p = 1'b0;
		sdin_s = 1'b0;
		ti = 256;
		ri = 256;
		cmd_frame = '0;
		short_word = '0;
		forever #62.5 sclk = ~sclk;
	end
	// Sync arrives after the rise, so the first bit is put out here
	always @(posedge sync) begin
		tx_p = mk(reply_p);
		tx_s = mk(reply_s);
		ti = 0;
		ri = 0;
		sdin_p = tx_p[255];
		sdin_s = tx_s[255];
	end
	// Past the frame end the lines toggle, never a stale value
	always @(posedge sclk) begin
		ti = ti + 1;
		sdin_p = (ti < 256) ? tx_p[255 - ti] : ~sdin_p;
		sdin_s = (ti < 256) ? tx_s[255 - ti] : ~sdin_s;
	end
	// Sample mid-bit; keep the last command frame and the last nonzero 16-bit word
	always @(negedge sclk) begin
		if (ri < 256) begin
			rx[255 - ri] = sdout;
			ri = ri + 1;
			if (ri == 16 && rx[255:240] != '0) short_word = rx[255:240];
			if (ri == 256 && rx[254]) cmd_frame = rx;
		end
	end
endmodule // csc_codec_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import csc_pkg::*;;
	logic mclk, rst, wr, rd, sclk, sdin_p, sdin_s, sdout, sync, irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, got;
	logic [7:0] v[5];
	logic [23:0] rp, rs, r;
	logic [255:0] cf;
	logic [15:0] sw;
	int failures, tests_run;

	csc_top csc_top_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sclk(sclk), .sdin_p(sdin_p), .sdin_s(sdin_s),
		.sdout(sdout), .sync(sync), .irq(irq));
	csc_codec_model csc_codec_model_i (.sync(sync), .sdout(sdout), .reply_p(rp),
		.reply_s(rs), .sclk(sclk), .sdin_p(sdin_p), .sdin_s(sdin_s), .cmd_frame(cf),
		.short_word(sw));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Callers leave one edge before the next write
	task automatic wrr(input logic [15:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 got = rdata;
		@(posedge mclk);
		chk(got, e);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		chk({7'h0, irq}, 8'h01);
	endtask
	task automatic results;
		$display("tests %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// A hang costs a mismatch; normal run is about nine AC97 frames
	initial begin
		#800000;
		failures++;
		results();
	end

	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		rp = {1'b1, 23'h0};
		rs = '0;
		failures = 0;
		tests_run = 0;
		void'($urandom(68902));
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 5; i++) rdc(OFS_SLOT_HIGH + 16'(i), 8'h00);
		rdc(16'h0000, 8'h00);
		rdc(16'hffdc, 8'h00);
		// Ones pushed into read-only and reserved bits must not stick
		for (int i = 0; i < 5; i++) begin
			v[i] = 8'($urandom) | ((i < 2) ? 8'h67 : 8'h00);
			if (i == 4) v[i][7] = 1'b0;
			wrr(OFS_SLOT_HIGH + 16'(i), v[i]);
			rdc(OFS_SLOT_HIGH + 16'(i), v[i] & ((i == 0) ? 8'h9f : (i == 1) ? 8'hf8 : 8'hff));
		end
		wrr(OFS_CTRL, 8'h01);
		@(posedge mclk);
		repeat (9000) @(posedge mclk);
		rdc(OFS_SLOT_HIGH, v[0] & 8'h9f | 8'h40);
		rdc(OFS_IRQ_STAT, 8'h03);
		chk({7'h0, irq}, 8'h00);
		wrr(OFS_IRQ_EN, 8'h03);
		@(posedge mclk);
		wait_irq();
		wrr(OFS_IRQ_CLR, 8'h07);
		repeat (3) @(posedge mclk);
		chk({7'h0, irq}, 8'h00);
		wrr(OFS_IRQ_EN, 8'h01);
		@(posedge mclk);
		wrr(OFS_CTRL, 8'h0d);
		@(posedge mclk);
		for (int i = 0; i < 5; i++) begin
			v[i] = 8'($urandom);
			if (i == 0) v[i][7] = 1'b1;
			if (i == 4) v[i][7] = 1'b0;
			wrr(OFS_SLOT_HIGH + 16'(i), v[i]);
			@(posedge mclk);
		end
		wait_irq();
		chk(cf[255:248], {v[0][7], 2'b11, v[0][4:0]});
		chk(cf[247:240] & 8'hfb, {v[1][7:3], 3'h3});
		chk(cf[239:232], v[4]);
		chk(cf[219:212], v[2]);
		chk(cf[211:204], v[3]);
		wrr(OFS_IRQ_CLR, 8'h01);
		@(posedge mclk);
		// Reads from the primary, then from a secondary codec
		for (int k = 0; k < 3; k += 2) begin
			rp = {1'b1, 23'($urandom)};
			rs = {k == 2, 23'($urandom)};
			r = k ? rs : rp;
			wrr(OFS_CTRL, 8'h01 | 8'(k << 2));
			@(posedge mclk);
			wrr(OFS_CMD_ADDR, {1'b1, 7'($urandom)});
			@(posedge mclk);
			wait_irq();
			chk({5'h0, cf[253], cf[241:240]}, 8'(k));
			rdc(OFS_CMD_ADDR, {1'b1, r[22:16]});
			rdc(OFS_DATA_HIGH, r[15:8]);
			rdc(OFS_DATA_LOW, r[7:0]);
			rdc(OFS_SLOT_HIGH, (v[0] & 8'h9f) | 8'h40 | 8'(k << 4));
			wrr(OFS_IRQ_CLR, 8'h01);
			@(posedge mclk);
		end
		// Short-address mode: one 16-bit word, ready flags must hold
		wrr(OFS_CTRL, 8'h03);
		@(posedge mclk);
		rp = '0;
		rs = '0;
		wrr(OFS_DATA_LOW, v[3]);
		@(posedge mclk);
		v[4] = (8'($urandom) & 8'h5f) | 8'h01;
		wrr(OFS_CMD_ADDR, v[4]);
		@(posedge mclk);
		wait_irq();
		chk(sw[15:8], v[4]);
		chk(sw[7:0], v[3]);
		rdc(OFS_SLOT_HIGH, (v[0] & 8'h9f) | 8'h60);
		results();
	end
endmodule // tb_top
